// >>> src/fsc_buf.sv
/*
  Two-entry buffer for program words, valid/ready on both sides.
  Assumes a synchronous active-high reset and a single clock.
*/
`timescale 1ns/1ps
`default_nettype none
module fsc_buf
  import fsc_pkg::*;
#(
  parameter int W = PAY_W
) (
  input  wire logic         clk_in,
  input  wire logic         srst_in,
  fsc_fifo_if.snk           push,
  output logic              pop_valid_out,
  input  wire logic         pop_ready_in,
  output logic [W-1:0]      pop_data_out
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic              wp;
    logic              rp;
    logic [1:0]        cnt;
  } fsc_buf_s;

  fsc_buf_s s;
  fsc_buf_s next_s;
  logic     do_push;
  logic     do_pop;

  assign push.ready    = (s.cnt != 2'h2);
  assign pop_valid_out = (s.cnt != 2'h0);
  assign pop_data_out  = s.mem[s.rp];
  assign do_push       = push.valid & push.ready;
  assign do_pop        = pop_valid_out & pop_ready_in;

  always_comb
  begin
    next_s = s;
    if (do_push)
    begin
      next_s.mem[s.wp] = push.data;
      next_s.wp        = ~s.wp;
    end
    if (do_pop)
      next_s.rp = ~s.rp;
    next_s.cnt = s.cnt + {1'b0, do_push} - {1'b0, do_pop};
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      s <= '0;
    else
      s <= next_s;
  end

  property p_buf_count;
    @(posedge clk_in) disable iff (srst_in)
    (s.cnt == 2'h2 && !pop_ready_in)
      |=> (s.cnt == 2'h2 && pop_data_out == $past(pop_data_out));
  endproperty
  a_buf_count: assert property (p_buf_count) else $error("buffer full not held");
endmodule : fsc_buf
`default_nettype wire

// >>> src/fsc_cmd.sv
/*
  Command interpreter for quad page program, deep power-down, secured OTP mode,
  security register read/write and protection scheme select.
  Assumes serial pins synchronous to clk_in and an array engine behind the buffer.
*/
// Summary of operation
// - Quad program: opcode, four address bytes, data bytes on four lines.
// - Program skipped when the page is protected under the active scheme.
// - Data past the page end wraps to the page start.
// - Busy flag held during program; cleared with write enable at completion.
// - Simple commands accept one-line or four-line opcodes; lines 3..1 ignored.
// - Power-down runs only if select rises right after eight opcode bits.
// - Power-down entered after the entry delay from select rising.
// - In power-down every command except wake is ignored.
// - Wake command or reset returns the device to standby.
// - OTP enter redirects program to the OTP region.
// - Main array access refused while OTP mode is active.
// - Once OTP is locked down, programs to it are rejected.
// - OTP exit restores main array addressing.
// - Security read answered at any time outside power-down and repeats while clocked.
// - Security write needs write enable; only sets lockdown, never cleared.
// - Security write rejected unless select rises right after the eight opcode bits.
// - Security register bit layout: scheme, fails, suspends, lockdown, factory.
// - Erase fail set when erase done reports failure, cleared by next good erase.
// - Program fail set on failure or protection, cleared by next good program.
// - Erase suspended flag follows suspend and resume, resets to zero.
// - Program suspended flag follows suspend and resume, resets to zero.
// - Factory lock bit shows whether the second OTP half is factory locked.
// - Scheme select picks block bits or per-sector bits, never both.
// - Scheme select command needs write enable and sets the bit permanently.
`timescale 1ns/1ps
`default_nettype none
module fsc_cmd
  import fsc_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire logic        cs_n_in,
  input  wire logic        sclk_in,
  input  wire logic [3:0]  sio_in,
  output logic [3:0]       sio_out,
  output logic [3:0]       sio_oe_n_out,
  input  wire logic        quad_enable_bit_in,
  input  wire logic        quad_command_mode_in,
  input  wire logic        block_protect_hit_in,
  input  wire logic        solid_protect_bit_in,
  input  wire logic        dynamic_protect_bit_in,
  input  wire logic        nv_scheme_in,
  input  wire logic        nv_lockdown_in,
  input  wire logic        factory_lock_in,
  input  wire logic        prog_done_in,
  input  wire logic        prog_fail_in,
  input  wire logic        erase_done_in,
  input  wire logic        erase_fail_in,
  input  wire logic        prog_suspend_in,
  input  wire logic        prog_resume_in,
  input  wire logic        erase_suspend_in,
  input  wire logic        erase_resume_in,
  output logic [31:0]      target_addr_out,
  output logic             otp_mode_out,
  output logic             deep_power_down_out,
  output logic             write_in_progress_flag_out,
  output logic             write_enable_latch_out,
  output logic             protect_scheme_select_out,
  output logic [7:0]       security_status_reg_out,
  output logic             lockdown_burn_out,
  output logic             scheme_burn_out,
  output logic             prog_valid_out,
  input  wire logic        prog_ready_in,
  output logic [1:0]       prog_kind_out,
  output logic             prog_otp_out,
  output logic [31:0]      prog_addr_out,
  output logic [7:0]       prog_data_out
);
  typedef struct packed {
    fsc_phase_e      ph;
    logic            cs_q;
    logic            sclk_q;
    logic [7:0]      sh;
    logic [7:0]      opc;
    logic [2:0]      bcnt;
    logic [2:0]      abytes;
    logic [31:0]     addr;
    logic            got;
    logic            bad;
    logic            pend;
    fsc_kind_e       pkind;
    logic            write_enable_latch;
    logic            write_in_progress_flag;
    logic            otp;
    logic            deep;
    logic            dp_pend;
    logic [DC_W-1:0] dcnt;
    logic            protect_scheme_select;
    logic            efail;
    logic            pfail;
    logic            erase_suspended_flag;
    logic            program_suspended_flag;
    logic            otp_lockdown_bit;
    logic            factory;
    logic [3:0]      dout;
    logic            otp_lockdown_bit_set;
    logic            protect_scheme_select_set;
  } fsc_state_s;

  fsc_state_s        s;
  fsc_state_s        next_s;
  fsc_fifo_if #(.W(PAY_W)) pq ();
  logic              cs_rise;
  logic              cs_fall;
  logic              sclk_rise;
  logic              sclk_fall;
  logic              qm;
  logic [3:0]        bsum;
  logic [7:0]        nsh;
  logic [7:0]        sec;
  logic              qpp_ok;
  logic              otp_blk;
  logic              blocked;
  logic              exec_ok;
  logic              end_ok;
  logic [PAY_W-1:0]  pop_data;

  //////////////////////////////////////////////////////////////////////////////
  // Edge detection and decode helpers

  function automatic logic [PAY_W-1:0] pack_word(input fsc_kind_e k, input logic o,
                                                  input logic [31:0] a, input logic [7:0] d);
    pack_word = {k, o, a, d};
  endfunction : pack_word

  assign cs_rise   = cs_n_in & ~s.cs_q;
  assign cs_fall   = ~cs_n_in & s.cs_q;
  assign sclk_rise = sclk_in & ~s.sclk_q;
  assign sclk_fall = ~sclk_in & s.sclk_q;
  assign qm        = quad_command_mode_in | (s.ph == PH_ADDR) | (s.ph == PH_DATA);
  assign bsum      = {1'b0, s.bcnt} + (qm ? 4'h4 : 4'h1);
  assign nsh       = qm ? {s.sh[3:0], sio_in} : {s.sh[6:0], sio_in[0]};
  assign sec       = {s.protect_scheme_select, s.efail, s.pfail, SEC_VOL_RST, s.erase_suspended_flag, s.program_suspended_flag, s.otp_lockdown_bit,
                      s.factory};
  assign qpp_ok    = s.write_enable_latch & quad_enable_bit_in & ~quad_command_mode_in & ~s.write_in_progress_flag
                     & ~(s.otp & s.otp_lockdown_bit);
  assign otp_blk   = (s.addr[31:OTP_TOP_BIT] != '0)
                     | (s.addr[OTP_HALF_BIT] ? s.factory : s.otp_lockdown_bit);
  assign blocked   = s.otp ? otp_blk
                     : (s.protect_scheme_select ? (solid_protect_bit_in | dynamic_protect_bit_in)
                                : block_protect_hit_in);
  assign exec_ok   = cs_rise & (s.ph == PH_WAIT) & ~s.bad & (s.bcnt == 3'h0);
  assign end_ok    = ~s.bad & s.got & (s.bcnt == 3'h0) & ~blocked;

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb
  begin
    next_s           = s;
    next_s.cs_q      = cs_n_in;
    next_s.sclk_q    = sclk_in;
    next_s.otp_lockdown_bit_set  = 1'b0;
    next_s.protect_scheme_select_set = 1'b0;
    pq.valid         = 1'b0;
    pq.data          = '0;
    if (s.dp_pend)
    begin
      if (s.dcnt == DC_W'(DP_CYC - 1))
      begin
        next_s.dp_pend = 1'b0;
        next_s.deep    = 1'b1;
      end
      else
        next_s.dcnt = s.dcnt + 1'b1;
    end
    if (prog_done_in)
    begin
      next_s.write_in_progress_flag   = 1'b0;
      next_s.write_enable_latch   = 1'b0;
      next_s.pfail = prog_fail_in;
    end
    if (erase_done_in)
      next_s.efail = erase_fail_in;
    if (prog_resume_in)
      next_s.program_suspended_flag = 1'b0;
    if (prog_suspend_in)
      next_s.program_suspended_flag = 1'b1;
    if (erase_resume_in)
      next_s.erase_suspended_flag = 1'b0;
    if (erase_suspend_in)
      next_s.erase_suspended_flag = 1'b1;
    if (cs_fall)
    begin
      next_s.ph     = PH_OPC;
      next_s.bcnt   = 3'h0;
      next_s.abytes = 3'h0;
      next_s.got    = 1'b0;
      next_s.bad    = 1'b0;
    end
    else if (!cs_n_in && sclk_rise && s.ph != PH_RDOUT)
    begin
      next_s.sh   = nsh;
      next_s.bcnt = bsum[2:0];
      unique case (s.ph)
        PH_OPC:
          if (bsum[3])
          begin
            next_s.opc = nsh;
            if (s.deep)
              next_s.ph = (nsh == OPC_WAKE) ? PH_WAIT : PH_IGNORE;
            else if (nsh == OPC_SEC_RD)
            begin
              next_s.ph = PH_RDOUT;
              next_s.sh = sec;
            end
            else if (nsh == OPC_QPP)
              next_s.ph = qpp_ok ? PH_ADDR : PH_IGNORE;
            else
              next_s.ph = PH_WAIT;
          end
        PH_WAIT:
          next_s.bad = 1'b1;
        PH_ADDR:
          if (bsum[3])
          begin
            next_s.addr   = {s.addr[23:0], nsh};
            next_s.abytes = s.abytes + 3'h1;
            if (s.abytes == 3'(ADDR_BYTES - 1))
              next_s.ph = PH_DATA;
          end
        PH_DATA:
          if (bsum[3])
          begin
            if (pq.ready)
            begin
              pq.valid         = 1'b1;
              pq.data          = pack_word(FSC_K_DATA, s.otp, s.addr, nsh);
              next_s.addr[7:0] = s.addr[7:0] + 8'h01;
              next_s.got       = 1'b1;
            end
            else
              next_s.bad = 1'b1;
          end
        PH_IDLE, PH_IGNORE:
          ;
        default:
          next_s.ph = PH_IGNORE;
      endcase
    end
    else if (!cs_n_in && sclk_fall && s.ph == PH_RDOUT)
    begin
      if (quad_command_mode_in)
      begin
        next_s.dout = s.sh[7:4];
        next_s.sh   = {s.sh[3:0], s.sh[7:4]};
      end
      else
      begin
        next_s.dout = {2'b00, s.sh[7], 1'b0};
        next_s.sh   = {s.sh[6:0], s.sh[7]};
      end
    end
    if (cs_rise)
    begin
      next_s.ph = PH_IDLE;
      if (s.ph == PH_DATA)
      begin
        if (end_ok)
          next_s.write_in_progress_flag = 1'b1;
        else if (blocked)
          next_s.pfail = 1'b1;
        if (pq.ready)
        begin
          pq.valid = 1'b1;
          pq.data  = pack_word(end_ok ? FSC_K_COMMIT : FSC_K_ABORT, s.otp, s.addr, 8'h00);
        end
        else
        begin
          next_s.pend  = 1'b1;
          next_s.pkind = end_ok ? FSC_K_COMMIT : FSC_K_ABORT;
        end
      end
    end
    else if (s.pend && pq.ready && !pq.valid)
    begin
      pq.valid    = 1'b1;
      pq.data     = pack_word(s.pkind, s.otp, s.addr, 8'h00);
      next_s.pend = 1'b0;
    end
    if (exec_ok)
    begin
      case (s.opc)
        OPC_DP:
        begin
          next_s.dp_pend = 1'b1;
          next_s.dcnt    = '0;
        end
        OPC_WAKE:
        begin
          next_s.deep    = 1'b0;
          next_s.dp_pend = 1'b0;
        end
        OPC_OTP_ENTER:
          next_s.otp = 1'b1;
        OPC_OTP_EXIT:
          next_s.otp = 1'b0;
        OPC_WRITE_ENABLE_CMD:
          next_s.write_enable_latch = 1'b1;
        OPC_SEC_WR:
          if (s.write_enable_latch)
          begin
            next_s.write_enable_latch = 1'b0;
            if (!s.otp_lockdown_bit)
            begin
              next_s.otp_lockdown_bit     = 1'b1;
              next_s.otp_lockdown_bit_set = 1'b1;
            end
          end
        OPC_SCHEME:
          if (s.write_enable_latch)
          begin
            next_s.write_enable_latch = 1'b0;
            if (!s.protect_scheme_select)
            begin
              next_s.protect_scheme_select     = 1'b1;
              next_s.protect_scheme_select_set = 1'b1;
            end
          end
        default:
          ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register; one-time bits reload from their cells at reset

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      s         <= '0;
      s.ph      <= PH_IDLE;
      s.cs_q    <= 1'b1;
      s.pkind   <= FSC_K_DATA;
      s.protect_scheme_select   <= nv_scheme_in;
      s.otp_lockdown_bit    <= nv_lockdown_in;
      s.factory <= factory_lock_in;
    end
    else
      s <= next_s;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Program buffer and outputs

  fsc_buf #(.W(PAY_W)) u_buf (
    .clk_in        (clk_in),
    .srst_in       (srst_in),
    .push          (pq),
    .pop_valid_out (prog_valid_out),
    .pop_ready_in  (prog_ready_in),
    .pop_data_out  (pop_data)
  );

  assign prog_kind_out              = pop_data[42:41];
  assign prog_otp_out               = pop_data[40];
  assign prog_addr_out              = pop_data[39:8];
  assign prog_data_out              = pop_data[7:0];
  assign sio_out                    = s.dout;
  assign sio_oe_n_out               = (s.ph == PH_RDOUT && !cs_n_in)
                                      ? (quad_command_mode_in ? OE_N_QPI_RD : OE_N_SPI_RD)
                                      : OE_N_OFF;
  assign target_addr_out            = s.addr;
  assign otp_mode_out               = s.otp;
  assign deep_power_down_out        = s.deep;
  assign write_in_progress_flag_out = s.write_in_progress_flag;
  assign write_enable_latch_out     = s.write_enable_latch;
  assign protect_scheme_select_out  = s.protect_scheme_select;
  assign security_status_reg_out    = sec;
  assign lockdown_burn_out          = s.otp_lockdown_bit_set;
  assign scheme_burn_out            = s.protect_scheme_select_set;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_dp_delay;
    @(posedge clk_in) disable iff (srst_in)
    $rose(s.deep) |-> $past(s.dp_pend) && ($past(s.dcnt) == DC_W'(DP_CYC - 1));
  endproperty
  a_dp_delay: assert property (p_dp_delay) else $error("early power-down");

  property p_dp_ignore;
    @(posedge clk_in) disable iff (srst_in)
    (s.deep && cs_rise && s.opc != OPC_WAKE) |=> s.deep && (s.otp == $past(s.otp));
  endproperty
  a_dp_ignore: assert property (p_dp_ignore) else $error("command run in power-down");

  property p_wake;
    @(posedge clk_in) disable iff (srst_in)
    (s.deep && exec_ok && s.opc == OPC_WAKE) |=> !s.deep ##1 !s.deep;
  endproperty
  a_wake: assert property (p_wake) else $error("wake not honoured");

  property p_dp_exact;
    @(posedge clk_in) disable iff (srst_in)
    $rose(s.dp_pend) |-> $past(s.opc == OPC_DP && s.bcnt == 3'h0 && !s.bad);
  endproperty
  a_dp_exact: assert property (p_dp_exact) else $error("power-down off boundary");

  property p_qpp_gate;
    @(posedge clk_in) disable iff (srst_in)
    $rose(s.write_in_progress_flag) |-> $past(s.write_enable_latch && s.got && !blocked && !quad_command_mode_in);
  endproperty
  a_qpp_gate: assert property (p_qpp_gate) else $error("program without enable");

  property p_done;
    @(posedge clk_in) disable iff (srst_in)
    (prog_done_in && s.write_in_progress_flag && !cs_rise) |=> !s.write_in_progress_flag && !s.write_enable_latch;
  endproperty
  a_done: assert property (p_done) else $error("busy or latch not cleared");

  property p_lock_sticky;
    @(posedge clk_in) disable iff (srst_in)
    s.otp_lockdown_bit |=> s.otp_lockdown_bit ##1 s.otp_lockdown_bit;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lockdown cleared");

  property p_scheme;
    @(posedge clk_in) disable iff (srst_in)
    $rose(s.protect_scheme_select) |-> $past(s.write_enable_latch) && scheme_burn_out;
  endproperty
  a_scheme: assert property (p_scheme) else $error("scheme set without latch");

  property p_pfail;
    @(posedge clk_in) disable iff (srst_in)
    (prog_done_in && prog_fail_in) |=> s.pfail && security_status_reg_out[SEC_PFAIL];
  endproperty
  a_pfail: assert property (p_pfail) else $error("program fail not shown");

  property p_rd_msb;
    @(posedge clk_in) disable iff (srst_in)
    (s.ph == PH_RDOUT && sclk_fall && !cs_n_in && !quad_command_mode_in)
      |=> sio_out[1] == $past(s.sh[7]);
  endproperty
  a_rd_msb: assert property (p_rd_msb) else $error("read order wrong");
endmodule : fsc_cmd
`default_nettype wire

// >>> src/fsc_fifo_if.sv
/*
  Valid/ready carrier between the command interpreter and its program buffer.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface fsc_fifo_if #(parameter int W = 43) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : fsc_fifo_if
`default_nettype wire

// >>> src/fsc_pkg.sv
/*
  Shared constants and types for the serial flash security and power command block.
  Assumes a 40 MHz system clock; serial pins are sampled as synchronous inputs.
*/
package fsc_pkg;
  localparam int           CLK_MHZ       = 40;
  localparam int           DP_ENTRY_NS   = 10000;
  localparam int           DP_CYC        = (DP_ENTRY_NS * CLK_MHZ + 999) / 1000;
  localparam int           DC_W          = $clog2(DP_CYC + 1);
  localparam int           ADDR_BYTES    = 4;
  localparam int           OTP_TOP_BIT   = 10;
  localparam int           OTP_HALF_BIT  = 9;
  localparam int           PAY_W         = 43;
  localparam logic [7:0]   OPC_QPP       = 8'h38;
  localparam logic [7:0]   OPC_DP        = 8'hB9;
  localparam logic [7:0]   OPC_WAKE      = 8'hAB;
  localparam logic [7:0]   OPC_OTP_ENTER = 8'hB1;
  localparam logic [7:0]   OPC_OTP_EXIT  = 8'hC1;
  localparam logic [7:0]   OPC_SEC_RD    = 8'h2B;
  localparam logic [7:0]   OPC_SEC_WR    = 8'h2F;
  localparam logic [7:0]   OPC_WRITE_ENABLE_CMD      = 8'h06;
  localparam logic [7:0]   OPC_SCHEME    = 8'h68;
  localparam int           SEC_SCHEME    = 7;
  localparam int           SEC_EFAIL     = 6;
  localparam int           SEC_PFAIL     = 5;
  localparam int           SEC_RSVD      = 4;
  localparam int           SEC_ESB       = 3;
  localparam int           SEC_PSB       = 2;
  localparam int           SEC_LOCK      = 1;
  localparam int           SEC_FACTORY   = 0;
  localparam logic         SEC_VOL_RST   = 1'b0;
  localparam logic [3:0]   OE_N_SPI_RD   = 4'hD;
  localparam logic [3:0]   OE_N_QPI_RD   = 4'h0;
  localparam logic [3:0]   OE_N_OFF      = 4'hF;

  typedef enum logic [1:0] {
    FSC_K_DATA   = 2'b00,
    FSC_K_COMMIT = 2'b01,
    FSC_K_ABORT  = 2'b10
  } fsc_kind_e;

  typedef enum logic [2:0] {
    PH_IDLE   = 3'b000,
    PH_OPC    = 3'b001,
    PH_WAIT   = 3'b010,
    PH_ADDR   = 3'b011,
    PH_DATA   = 3'b100,
    PH_RDOUT  = 3'b101,
    PH_IGNORE = 3'b110
  } fsc_phase_e;
endpackage : fsc_pkg

// >>> testbench/fsc_host_model.sv
/*
  Host controller model driving select, serial clock and four data lines.
  Assumes the bench resolves the shared data wires from the enables.
*/
`timescale 1ns/1ps
`default_nettype none
module fsc_host_model (
  input  wire logic       clk_in,
  input  wire logic [3:0] rd_in,
  output logic            cs_n_out,
  output logic            sclk_out,
  output logic [3:0]      sio_out
);
  initial
  begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    sio_out  = 4'h0;
  end
  task automatic beat(input logic [3:0] v, output logic b);
    sio_out  <= v;
    sclk_out <= 1'b0;
    repeat (2) @(posedge clk_in);
    b = rd_in[1];
    sclk_out <= 1'b1;
    repeat (2) @(posedge clk_in);
  endtask : beat
  task automatic xfer(input logic [7:0] d, input bit quad, output logic [7:0] r);
    logic b;
    r = 8'h00;
    if (quad)
    begin
      beat(d[7:4], b);
      beat(d[3:0], b);
    end
    else
      for (int i = 7; i >= 0; i--)
      begin
        beat({~d[i], d[i], i[0], d[i]}, b);
        r = {r[6:0], b};
      end
  endtask : xfer
  task automatic start();
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask : start
  task automatic stop();
    sclk_out <= 1'b0;
    repeat (2) @(posedge clk_in);
    cs_n_out <= 1'b1;
    repeat (3) @(posedge clk_in);
  endtask : stop
endmodule : fsc_host_model
`default_nettype wire

// >>> testbench/tb.sv
/*
  Self-checking bench for the flash command block.
  Assumes the package, buffer, carrier and host model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb
  import fsc_pkg::*;
;
  logic        clk_in = 1'b0, srst = 1'b1, qe = 1'b0, qm = 1'b0, bp = 1'b0, pr = 1'b1;
  logic [7:0]  ev = 8'h00, sec, r, pd;
  logic [3:0]  h_sio, d_sio, oe_n, sio_w;
  logic        cs_n, sclk, otp, dpd, write_in_progress_flag, write_enable_latch, pss, pv, pot, b, lb, sb;
  logic        solid_protect_bit = 1'b0, lbs = 1'b0, sbs = 1'b0;
  logic [1:0]  kind;
  logic [31:0] pa, ta;
  logic [42:0] q[$];
  logic [7:0]  evs [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h30, 8'h10};
  logic [7:0]  exps [6] = '{8'h05, 8'h01, 8'h09, 8'h01, 8'h41, 8'h01};
  int          error_cnt = 0, num_checks = 0, n;
  always #12.5 clk_in = ~clk_in;
  assign sio_w = (~oe_n & d_sio) | (oe_n & h_sio);
  always @(posedge clk_in) if (pv && pr) q.push_back({kind, pot, pa, pd});
  always @(posedge clk_in) if (!srst) {lbs, sbs} <= {lbs | lb, sbs | sb};
  fsc_host_model i_fsc_host_model (.clk_in(clk_in), .rd_in(sio_w), .cs_n_out(cs_n),
    .sclk_out(sclk), .sio_out(h_sio));
  fsc_cmd i_fsc_cmd (.clk_in(clk_in), .srst_in(srst), .cs_n_in(cs_n), .sclk_in(sclk),
    .sio_in(sio_w), .sio_out(d_sio), .sio_oe_n_out(oe_n), .quad_enable_bit_in(qe),
    .quad_command_mode_in(qm), .block_protect_hit_in(bp), .solid_protect_bit_in(solid_protect_bit),
    .dynamic_protect_bit_in(1'b0), .nv_scheme_in(1'b0), .nv_lockdown_in(1'b0),
    .factory_lock_in(1'b1), .prog_done_in(ev[6]), .prog_fail_in(ev[7]),
    .erase_done_in(ev[4]), .erase_fail_in(ev[5]), .prog_suspend_in(ev[0]),
    .prog_resume_in(ev[1]), .erase_suspend_in(ev[2]), .erase_resume_in(ev[3]),
    .target_addr_out(ta), .otp_mode_out(otp), .deep_power_down_out(dpd),
    .write_in_progress_flag_out(write_in_progress_flag), .write_enable_latch_out(write_enable_latch),
    .protect_scheme_select_out(pss), .security_status_reg_out(sec), .lockdown_burn_out(lb),
    .scheme_burn_out(sb), .prog_valid_out(pv), .prog_ready_in(pr), .prog_kind_out(kind),
    .prog_otp_out(pot), .prog_addr_out(pa), .prog_data_out(pd));
  task automatic chk(input string nm, input logic [42:0] e, input logic [42:0] s);
    num_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic done(input string t);
    $display("test %s ended, checks %0d", t, num_checks);
  endtask : done
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  task automatic pulse(input logic [7:0] v);
    @(posedge clk_in);
    ev <= v;
    @(posedge clk_in);
    ev <= 8'h00;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
  endtask : pulse
  task automatic cmd(input logic [7:0] op, input bit quad = 1'b0, input int extra = 0);
    i_fsc_host_model.start();
    i_fsc_host_model.xfer(op, quad, r);
    repeat (extra) i_fsc_host_model.beat(4'h0, b);
    i_fsc_host_model.stop();
    @(negedge clk_in);
  endtask : cmd
  task automatic qprog(input logic [31:0] a, input int nb, input logic [7:0] d0,
                       input bit quad = 1'b0);
    i_fsc_host_model.start();
    i_fsc_host_model.xfer(OPC_QPP, quad, r);
    for (int k = 3; k >= 0; k--) i_fsc_host_model.xfer(a[8*k +: 8], 1'b1, r);
    for (int k = 0; k < nb; k++)
    begin
      i_fsc_host_model.xfer(d0 + 8'(k), 1'b1, r);
      if (k == 1 && !pr)
      begin
        @(negedge clk_in);
        chk("buf_head", {1'b1, d0}, {pv, pd});
        @(posedge clk_in);
        pr <= 1'b1;
      end
    end
    i_fsc_host_model.stop();
    @(negedge clk_in);
  endtask : qprog
  initial
  begin
    repeat (20000) @(posedge clk_in);
    error_cnt++;
    final_report();
  end
  initial
  begin
    repeat (20) @(posedge clk_in);
    srst <= 1'b0;
    @(negedge clk_in);
    chk("sec_rst", 8'h01, sec);
    chk("flag_rst", 5'h00, {write_in_progress_flag, write_enable_latch, otp, dpd, pss});
    done("reset");
    i_fsc_host_model.start();
    i_fsc_host_model.xfer(OPC_SEC_RD, 1'b0, r);
    i_fsc_host_model.xfer(8'h00, 1'b0, r);
    chk("rd1", 8'h01, r);
    i_fsc_host_model.xfer(8'h00, 1'b0, r);
    chk("rd2", 8'h01, r);
    i_fsc_host_model.stop();
    done("read");
    @(posedge clk_in);
    qe <= 1'b1;
    qprog(32'h0, 1, 8'h11);
    chk("no_wel", 0, 43'(q.size()));
    cmd(OPC_WRITE_ENABLE_CMD);
    chk("wel", 1, write_enable_latch);
    @(posedge clk_in);
    bp <= 1'b1;
    qprog(32'h0, 1, 8'h5A);
    chk("prot", FSC_K_ABORT, q[$][42:41]);
    chk("pfail", 8'h21, sec);
    q.delete();
    done("protect");
    @(posedge clk_in);
    bp <= 1'b0;
    pr <= 1'b0;
    cmd(OPC_WRITE_ENABLE_CMD);
    qprog(32'h1FE, 4, 8'hA0);
    for (int k = 0; k < 4; k++)
      chk("word", {FSC_K_DATA, 1'b0, 24'h1, 8'hFE + 8'(k), 8'hA0 + 8'(k)}, q[k]);
    chk("commit", FSC_K_COMMIT, q[4][42:41]);
    chk("busy", 2'b11, {write_in_progress_flag, write_enable_latch});
    chk("taddr", 32'h102, ta);
    pulse(8'h40);
    chk("prog_end", 10'h001, {write_in_progress_flag, write_enable_latch, sec});
    q.delete();
    done("program");
    for (int k = 0; k < 6; k++)
    begin
      pulse(evs[k]);
      chk("event", exps[k], sec);
    end
    done("events");
    cmd(OPC_OTP_ENTER);
    cmd(OPC_WRITE_ENABLE_CMD);
    qprog(32'h400, 1, 8'h33);
    chk("otp_main", {FSC_K_ABORT, 1'b1}, q[$][42:40]);
    qprog(32'h10, 1, 8'h44);
    chk("otp_word", {FSC_K_DATA, 1'b1, 32'h10, 8'h44}, q[2]);
    pulse(8'h40);
    chk("otp_done", 10'h001, {write_in_progress_flag, write_enable_latch, sec});
    cmd(OPC_OTP_EXIT);
    q.delete();
    done("otp_prog");
    cmd(OPC_SEC_WR);
    chk("wr_nowel", 8'h01, sec);
    cmd(OPC_WRITE_ENABLE_CMD);
    cmd(OPC_SEC_WR, 1'b0, 1);
    chk("wr_offb", 10'h001, {lbs, sbs, sec});
    cmd(OPC_WRITE_ENABLE_CMD);
    cmd(OPC_SEC_WR);
    chk("lock", 11'h403, {lbs, sbs, write_enable_latch, sec});
    cmd(OPC_WRITE_ENABLE_CMD);
    cmd(OPC_SCHEME);
    chk("scheme", 11'h783, {lbs, sbs, pss, sec});
    done("secwrite");
    @(posedge clk_in);
    solid_protect_bit <= 1'b1;
    cmd(OPC_WRITE_ENABLE_CMD);
    qprog(32'h0, 1, 8'h77);
    chk("spb", FSC_K_ABORT, q[$][42:41]);
    @(posedge clk_in);
    {bp, solid_protect_bit} <= 2'b10;
    qprog(32'h0, 1, 8'h78);
    chk("bp_off", FSC_K_COMMIT, q[$][42:41]);
    pulse(8'h40);
    q.delete();
    done("scheme");
    @(posedge clk_in);
    qm <= 1'b1;
    cmd(OPC_WRITE_ENABLE_CMD, 1'b1);
    qprog(32'h0, 1, 8'h66, 1'b1);
    chk("qpi_qpp", 2'b11, {q.size() == 0, write_enable_latch});
    cmd(OPC_OTP_ENTER, 1'b1);
    chk("otp_on", 1, otp);
    @(posedge clk_in);
    qm <= 1'b0;
    cmd(OPC_WRITE_ENABLE_CMD);
    qprog(32'h0, 1, 8'h22);
    chk("otp_lock", 0, 43'(q.size()));
    cmd(OPC_OTP_EXIT);
    chk("otp_off", 0, otp);
    done("otp");
    cmd(OPC_DP, 1'b0, 1);
    repeat (DP_CYC + 20) @(posedge clk_in);
    chk("dp_extra", 0, dpd);
    cmd(OPC_DP);
    for (n = 0; n < 2 * DP_CYC && dpd !== 1'b1; n++) @(posedge clk_in);
    chk("dp_delay", 1, 43'(n >= DP_CYC - 8 && n <= DP_CYC + 2));
    cmd(OPC_OTP_ENTER);
    chk("dp_ignore", 0, otp);
    cmd(OPC_WAKE);
    chk("wake", 0, dpd);
    done("power");
    final_report();
  end
endmodule : tb
`default_nettype wire
